// [test/led_sink_error_detect_control_tb_top.sv]
// testbench: host and sink driver joined pin to pin, plus a hand-driven second link
`default_nettype none
module led_sink_error_detect_control_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [15:0] open_f = 16'h0000;
  logic [15:0] short_f = 16'h0000;
  logic [15:0] data_i = 16'h0000;
  logic load_i = 1'b0;
  logic detect_i = 1'b0;
  logic busy_o;
  logic [15:0] result_o;
  logic result_valid_o;
  logic [15:0] chan_o;
  logic shut_o;
  logic eval_o;
  logic mode2_o;
  logic [15:0] exp_q[$];
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  integer seed = 32'hd946;
  lsedc_if bus ();
  lsedc_if bus2 ();
  always #12.5 ref_clk_i = ~ref_clk_i;
  lsedc_device i_lsedc_device (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .pins(bus.device),
    .open_fault_i(open_f), .short_fault_i(short_f), .sink_channel_o(chan_o),
    .shutdown_o(shut_o), .detect_mode_o(), .evaluating_o(eval_o));
  lsedc_host i_lsedc_host (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .pins(bus.host),
    .data_i(data_i), .load_i(load_i), .detect_i(detect_i), .busy_o(busy_o),
    .result_o(result_o), .result_valid_o(result_valid_o));
  // second device faces the bench directly so broken sequences can be sent
  lsedc_device i_lsedc_device_2 (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .pins(bus2.device),
    .open_fault_i(16'h0000), .short_fault_i(16'h0000), .sink_channel_o(),
    .shutdown_o(), .detect_mode_o(mode2_o), .evaluating_o());
  lsedc_properties i_lsedc_properties (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .serial_in_pin(bus.serial_in_pin), .serial_out_pin(bus.serial_out_pin),
    .latch_and_detect_select(bus.latch_and_detect_select),
    .blank_and_detect_select(bus.blank_and_detect_select));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    if (num_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  // bounded wait, so a stuck busy shows as a mismatch rather than a hang
  task automatic wait_idle();
    int i;
    i = 0;
    tick(1);
    #1;
    while (busy_o !== 1'b0 && i < 400) begin
      tick(1);
      #1;
      i++;
    end
  endtask
  task automatic do_load(input logic [15:0] d);
    @(posedge ref_clk_i);
    data_i <= d;
    load_i <= 1'b1;
    @(posedge ref_clk_i);
    load_i <= 1'b0;
    wait_idle();
    tick(2);
    #1;
    check(16'(shut_o), 16'(d == 16'h0000), "shutdown");
    check(chan_o, lsedc_pkg::ALL_ZEROS, "blanked channels");
  endtask
  task automatic do_detect();
    int i;
    @(posedge ref_clk_i);
    open_f <= 16'($random(seed));
    short_f <= 16'($random(seed));
    detect_i <= 1'b1;
    @(posedge ref_clk_i);
    detect_i <= 1'b0;
    exp_q.push_back(~(open_f | short_f));
    i = 0;
    while (eval_o !== 1'b1 && i < 200) begin
      tick(1);
      #1;
      i++;
    end
    check(chan_o, lsedc_pkg::ALL_ONES, "detect channels");
    wait_idle();
  endtask
  task automatic seq2(input logic [4:0] lp, input logic exp);
    int i;
    for (i = 0; i < 5; i++) begin
      @(posedge ref_clk_i);
      bus2.blank_and_detect_select <= lsedc_pkg::BLANK_SEQ[i];
      bus2.latch_and_detect_select <= lp[i];
    end
    @(posedge ref_clk_i);
    bus2.blank_and_detect_select <= 1'b1;
    bus2.latch_and_detect_select <= 1'b0;
    tick(3);
    #1;
    check(16'(mode2_o), 16'(exp), "detect mode");
  endtask
  // ----------------------------------------
  // result monitor and timeout
  // ----------------------------------------
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      num_errors++;
      wrap_up();
    end
    if (result_valid_o === 1'b1) begin
      if (exp_q.size() != 0) check(result_o, exp_q.pop_front(), "result");
      else check(16'h0001, 16'h0000, "unexpected result");
    end
  end
  initial begin
    bus2.serial_in_pin = 1'b0;
    bus2.blank_and_detect_select = 1'b1;
    bus2.latch_and_detect_select = 1'b0;
    tick(16);
    srst_i <= 1'b0;
    #1;
    check(16'(shut_o), 16'h0001, "power-up shutdown");
    do_load(16'h0000);
    do_load(16'h8001);
    do_load(16'($random(seed)) | 16'h0100);
    do_detect();
    do_detect();
    do_load(16'h0000);
    seq2(5'h18, 1'b0);
    seq2(lsedc_pkg::LATCH_RESUME_SEQ, 1'b0);
    seq2(lsedc_pkg::LATCH_ENTRY_SEQ, 1'b1);
    seq2(lsedc_pkg::LATCH_ENTRY_SEQ, 1'b1);
    seq2(lsedc_pkg::LATCH_RESUME_SEQ, 1'b0);
    tick(5);
    check(16'(exp_q.size()), 16'h0000, "results pending");
    wrap_up();
  end
endmodule // led_sink_error_detect_control_tb_top
`default_nettype wire

// [test/lsedc_properties.sv]
// checker: pin-level properties of the host to sink driver link
`default_nettype none
module lsedc_properties (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // link pins
  input wire logic serial_in_pin,
  input wire logic serial_out_pin,
  input wire logic latch_and_detect_select,
  input wire logic blank_and_detect_select
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // helper history
  // ----------------------------------------
  logic [4:0] bh_q;
  logic [4:0] lh_q;
  logic [6:0] low_q;
  logic det_q;
  wire seq_w = (bh_q == lsedc_pkg::BLANK_SEQ);
  wire ent_w = seq_w && (lh_q == lsedc_pkg::LATCH_ENTRY_SEQ);
  wire res_w = seq_w && (lh_q == lsedc_pkg::LATCH_RESUME_SEQ);
  // saturate so a long blank-low stretch cannot wrap back to a short one
  wire [6:0] low_d = (low_q == 7'h7F) ? low_q : low_q + 7'h01;
  // newest sample in bit 4, so cycle 1 of a sequence lands in bit 0
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      bh_q <= 5'h1F;
      lh_q <= 5'h00;
      low_q <= 7'h00;
      det_q <= 1'b0;
    end else begin
      bh_q <= {blank_and_detect_select, bh_q[4:1]};
      lh_q <= {latch_and_detect_select, lh_q[4:1]};
      low_q <= blank_and_detect_select ? 7'h00 : low_d;
      det_q <= ent_w ? 1'b1 : (res_w ? 1'b0 : det_q);
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);
  a_reset_pins: assert property ($fell(srst_i) |-> blank_and_detect_select
    && !latch_and_detect_select && !serial_in_pin) else $error("pins not idle after reset");
  a_seq_known: assert property (seq_w |-> ent_w || res_w)
    else $error("sequence with unknown latch pattern");
  a_seq_alternate: assert property (seq_w |-> ent_w != det_q)
    else $error("entry and resume did not alternate");
  a_detect_ones: assert property (ent_w |-> (serial_in_pin && !latch_and_detect_select)[*8]
    ##1 (serial_in_pin && !latch_and_detect_select)[*7]
    ##1 (serial_in_pin && latch_and_detect_select))
    else $error("detection data not sixteen ones then latch");
  a_latch_then_blank: assert property (det_q && $fell(latch_and_detect_select)
    |-> ##[0:3] !blank_and_detect_select) else $error("no detection pass after latch");
  a_latch_pulse: assert property ($rose(latch_and_detect_select)
    |=> !latch_and_detect_select) else $error("latch pulse longer than one cycle");
  a_blank_dwell: assert property (blank_and_detect_select && low_q != 7'h00
    |-> low_q == 7'h01 || low_q > lsedc_pkg::DWELL_LAST) else $error("blank low too short");
  a_resume_bound: assert property (det_q && blank_and_detect_select
    && low_q > lsedc_pkg::DWELL_LAST |-> ##[16:60] res_w) else $error("no resume after read");
endmodule // lsedc_properties
`default_nettype wire

// [verilog/lsedc_device.sv]
// sink driver end: shift chain, storage latch, blanking, detection and power saving
`default_nettype none
// Operation
// [R1] host enters detection by five-cycle pin pattern
// [R2] detection mode samples data from sixth edge
// [R3] host shifts sixteen ones during detection
// [R4] host latches ones before detection pass
// [R5] blank low in detection evaluates channels
// [R6] host holds blank low at least 1 us
// [R7] blank high loads results into shift chain
// [R8] results use normal data bit order
// [R9] repeat detection only after resuming normal
// [R10] host resumes normal with latch held low
// [R11] entry and resume sequences must alternate
// [R12] current at most half programmed flags open
// [R13] output at least 2.6 V flags short
// [R14] no active latched bit enters shutdown
// [R15] device powers up in shutdown
// [R16] latch transparent high, holds when low
// [R17] blank high turns all channels off
// [R18] latched one switches channel on
// [R19] sequence pins sampled per edge, mismatch discards
// [R20] otherwise normal latch and enable behaviour
module lsedc_device (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // pins toward the host
  lsedc_if.device pins,
  // analog comparator results per channel (1 = fault seen)
  input wire logic [15:0] open_fault_i,
  input wire logic [15:0] short_fault_i,
  // channel drive and status
  output logic [15:0] sink_channel_o,
  output logic shutdown_o,
  output logic detect_mode_o,
  output logic evaluating_o
);
  // ----------------------------------------------------------------
  // sequence recogniser
  // ----------------------------------------------------------------
  logic [2:0] seq_cnt_q, seq_cnt_d;
  logic blank_ok, latch_entry_ok, latch_resume_ok, seq_match, seq_done;
  logic [15:0] shift_q, shift_d, store_q, sense_fault;
  logic det_q, eval_q, eval_d;
  // a sequence is only the pattern at cnt; a miss restarts, retrying cycle 1
  assign blank_ok = pins.blank_and_detect_select == lsedc_pkg::BLANK_SEQ[seq_cnt_q];
  assign latch_entry_ok =
    pins.latch_and_detect_select == lsedc_pkg::LATCH_ENTRY_SEQ[seq_cnt_q];
  assign latch_resume_ok =
    pins.latch_and_detect_select == lsedc_pkg::LATCH_RESUME_SEQ[seq_cnt_q];
  // only the pattern leading out of the present mode is watched
  assign seq_match = blank_ok && (det_q ? latch_resume_ok : latch_entry_ok); // see [R11]
  assign seq_done = seq_match && (seq_cnt_q == lsedc_pkg::SEQ_CNT_LAST);
  // a cycle-1 match after a miss restarts at cycle 2
  always_comb begin
    if (seq_done) begin
      seq_cnt_d = 3'h0;
    end else if (seq_match) begin
      seq_cnt_d = seq_cnt_q + 3'h1; // see [R19]
    end else if (pins.blank_and_detect_select == lsedc_pkg::BLANK_SEQ[0] &&
                 !pins.latch_and_detect_select) begin
      seq_cnt_d = 3'h1; // see [R19]
    end else begin
      seq_cnt_d = 3'h0;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      seq_cnt_q <= 3'h0;
    end else begin
      seq_cnt_q <= seq_cnt_d;
    end
  end
  // mode flag; entry takes effect so the sixth edge already samples data
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      det_q <= 1'b0; // see [R20]
    end else if (seq_done) begin
      det_q <= !det_q; // see [R2] [R9]
    end
  end
  // ----------------------------------------------------------------
  // shift chain, latch and detection capture
  // ----------------------------------------------------------------
  // evaluation window: blank low while in detection mode
  assign eval_d = det_q && !pins.blank_and_detect_select; // see [R5]
  assign sense_fault = open_fault_i | short_fault_i; // see [R12] [R13]
  // fault flags: one per channel, same position as display data
  always_comb begin
    if (eval_q && pins.blank_and_detect_select) begin
      shift_d = ~sense_fault & store_q; // see [R7] [R8]
    end else begin
      shift_d = {shift_q[14:0], pins.serial_in_pin};
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      shift_q <= lsedc_pkg::ALL_ZEROS;
      eval_q <= 1'b0;
    end else begin
      shift_q <= shift_d;
      eval_q <= eval_d;
    end
  end
  // transparent while the latch pin is high, modelled per edge
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      store_q <= lsedc_pkg::ALL_ZEROS; // see [R15]
    end else if (pins.latch_and_detect_select) begin
      store_q <= shift_d; // see [R16]
    end
  end
  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic [15:0] chan_d;
  logic [15:0] drive_q;
  logic sdo_q, shut_q;
  assign chan_d = pins.blank_and_detect_select ? lsedc_pkg::ALL_ZEROS : store_q; // see [R17] [R18]
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      drive_q <= lsedc_pkg::ALL_ZEROS;
      sdo_q <= 1'b0;
      shut_q <= 1'b1; // see [R15]
    end else begin
      drive_q <= chan_d;
      sdo_q <= shift_d[15];
      shut_q <= (store_q == lsedc_pkg::ALL_ZEROS); // see [R14]
    end
  end
  assign sink_channel_o = drive_q;
  assign pins.serial_out_pin = sdo_q;
  assign shutdown_o = shut_q;
  assign detect_mode_o = det_q;
  assign evaluating_o = eval_q;
endmodule : lsedc_device
`default_nettype wire

// [verilog/lsedc_host.sv]
// host end: drives the pin sequences, loads data and runs a detection pass
`default_nettype none
module lsedc_host (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // pins toward the device
  lsedc_if.host pins,
  // user side
  input wire logic [15:0] data_i,
  input wire logic load_i,
  input wire logic detect_i,
  output logic busy_o,
  output logic [15:0] result_o,
  output logic result_valid_o
);
  typedef enum logic [5:0] {
    LSEDC_IDLE = 6'h01, LSEDC_SHIFT = 6'h02, LSEDC_LATCH = 6'h04,
    LSEDC_SEQ = 6'h08, LSEDC_DWELL = 6'h10, LSEDC_READ = 6'h20
  } lsedc_state_t;
  lsedc_state_t state_q;
  logic [4:0] cnt_q;
  logic [6:0] dwell_q;
  logic [15:0] tx_q, rx_q;
  logic det_q, resume_q, after_q, oe_q, le_q, sdi_q, valid_q;
  logic seq_last, shift_last;
  assign seq_last = cnt_q[2:0] == lsedc_pkg::SEQ_CNT_LAST;
  assign shift_last = cnt_q == lsedc_pkg::CNT_LAST;
  // single sequential engine; detect runs entry, load ones, dwell, read, resume
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_q <= LSEDC_IDLE;
      cnt_q <= 5'h00;
      dwell_q <= '0;
      tx_q <= lsedc_pkg::ALL_ZEROS;
      rx_q <= lsedc_pkg::ALL_ZEROS;
      det_q <= 1'b0;
      resume_q <= 1'b0;
      after_q <= 1'b0;
      oe_q <= 1'b1;
      le_q <= 1'b0;
      sdi_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      valid_q <= 1'b0;
      le_q <= 1'b0;
      unique case (state_q)
        LSEDC_IDLE: begin
          cnt_q <= 5'h00;
          if (detect_i) begin
            resume_q <= 1'b0;
            state_q <= LSEDC_SEQ; // see [R1]
          end else if (load_i) begin
            tx_q <= data_i;
            det_q <= 1'b0;
            state_q <= LSEDC_SHIFT;
          end
        end
        LSEDC_SEQ: begin
          oe_q <= lsedc_pkg::BLANK_SEQ[cnt_q[2:0]]; // see [R1] [R10]
          le_q <= resume_q ? lsedc_pkg::LATCH_RESUME_SEQ[cnt_q[2:0]]
                           : lsedc_pkg::LATCH_ENTRY_SEQ[cnt_q[2:0]];
          cnt_q <= cnt_q + 5'h01;
          if (seq_last) begin
            cnt_q <= 5'h00;
            if (resume_q) begin
              state_q <= LSEDC_IDLE; // see [R9] [R11]
            end else begin
              tx_q <= lsedc_pkg::ALL_ONES; // see [R3]
              det_q <= 1'b1;
              state_q <= LSEDC_SHIFT; // see [R2]
            end
          end
        end
        LSEDC_SHIFT: begin
          sdi_q <= tx_q[15];
          tx_q <= {tx_q[14:0], 1'b0};
          cnt_q <= cnt_q + 5'h01;
          // every edge shifts, so the latch must be high on the edge that takes the last bit
          if (shift_last) begin
            le_q <= 1'b1; // see [R4]
            state_q <= LSEDC_LATCH;
          end
        end
        LSEDC_LATCH: begin
          cnt_q <= 5'h00;
          dwell_q <= '0;
          state_q <= det_q ? LSEDC_DWELL : LSEDC_IDLE;
          if (det_q) begin
            after_q <= 1'b1;
          end
        end
        LSEDC_DWELL: begin
          after_q <= 1'b0;
          oe_q <= after_q ? 1'b1 : 1'b0;
          if (!after_q) begin
            dwell_q <= dwell_q + 7'h01;
          end
          // low on edges with dwell 0..DWELL_LAST, a full DETECT_CYCLES stretch
          if (dwell_q == lsedc_pkg::DWELL_LAST + 7'h01) begin
            oe_q <= 1'b1; // see [R6]
            state_q <= LSEDC_READ;
          end
        end
        LSEDC_READ: begin
          // first edge captures results, then sixteen bits stream out msb first
          rx_q <= {rx_q[14:0], pins.serial_out_pin};
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == 5'h10) begin
            valid_q <= 1'b1;
            resume_q <= 1'b1;
            cnt_q <= 5'h00;
            state_q <= LSEDC_SEQ; // see [R10]
          end
        end
        default: state_q <= LSEDC_IDLE;
      endcase
    end
  end
  assign pins.blank_and_detect_select = oe_q;
  assign pins.latch_and_detect_select = le_q;
  assign pins.serial_in_pin = sdi_q;
  assign busy_o = state_q != LSEDC_IDLE;
  assign result_o = rx_q;
  assign result_valid_o = valid_q;
endmodule : lsedc_host
`default_nettype wire

// [verilog/lsedc_if.sv]
// interface: serial, latch and enable pins between host and sink driver
`default_nettype none
interface lsedc_if;
  logic serial_in_pin;
  logic serial_out_pin;
  logic latch_and_detect_select;
  logic blank_and_detect_select;
  modport device (
    input serial_in_pin, latch_and_detect_select, blank_and_detect_select,
    output serial_out_pin
  );
  modport host (
    output serial_in_pin, latch_and_detect_select, blank_and_detect_select,
    input serial_out_pin
  );
endinterface : lsedc_if
`default_nettype wire

// [verilog/lsedc_pkg.sv]
// package: constants shared by the sink driver and its host controller
`default_nettype none
package lsedc_pkg;
  localparam int CHANNELS = 16;
  localparam int SEQ_LEN = 5;
  // entry/resume pin patterns, cycle 1 in bit 0
  localparam logic [4:0] BLANK_SEQ = 5'h1D; // H L H H H
  localparam logic [4:0] LATCH_ENTRY_SEQ = 5'h08; // L L L H L
  localparam logic [4:0] LATCH_RESUME_SEQ = 5'h00; // L L L L L
  // detection dwell with the blank pin low
  localparam int DETECT_TIME_NS = 1000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int DETECT_CYCLES = (DETECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DWELL_W = 7;
  localparam logic [DWELL_W-1:0] DWELL_LAST = DWELL_W'(DETECT_CYCLES - 1);
  localparam logic [15:0] ALL_ONES = 16'hFFFF;
  localparam logic [15:0] ALL_ZEROS = 16'h0000;
  localparam logic [2:0] SEQ_CNT_LAST = 3'h4;
  localparam logic [4:0] CNT_LAST = 5'h0F;
endpackage : lsedc_pkg
`default_nettype wire
